/* common/tws_pkg.sv */
// constants, status codes and state types for the two-wire serial controller
// Behaviour
// - master SCL = clk / (16 + 2*divider*4^prescale)
// - slave timing ignores divider; clk >= 16x SCL
// - master clock waits while SCL held low
// - one 8-bit shift register for all bytes
// - hidden ack bit; sent from control, received reported
// - generate and detect START, repeated START, STOP
// - START/STOP detection runs during sleep
// - master monitors SDA; arbitration loss reported
// - compare received address with seven-bit own address
// - general call matched when enabled
// - address acknowledge follows control ack setting
// - address compare works in sleep, wakes CPU
// - other wake source aborts address match
// - flag set, status code loaded next cycle
// - status reads no-info code while flag low
// - SCL held low while flag set
// - flag after listed bus events
// - interrupt needs flag, local and global enables
// - writing one clears flag; software never sets
// - no operation while flag; resume on clear
// - no flag after master STOP
// - ack/nack of sent packet reported in status
// - address packet 7 bits MSB first, R/W, ack
// - address zero is the general call
// - data byte MSB first, ninth clock ack low
// - arbitration loss releases SDA, becomes slave
package tws_pkg;
  localparam int DIV_W     = 8;
  localparam int PS_W      = 2;
  localparam int HALF_W    = 16;
  localparam int HALF_BASE = 8;
  localparam int PS_SHIFT  = 2;
  localparam int ADDR_W    = 7;
  localparam int BYTE_W    = 8;
  localparam int CODE_W    = 5;
  localparam logic [ADDR_W-1:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BITS_DATA = 4'h8;
  localparam logic [3:0] BITS_PKT  = 4'h9;
  localparam logic [1:0] PH_FIRST  = 2'h0;
  localparam logic [1:0] PH_MID    = 2'h1;
  localparam logic [1:0] PH_LAST   = 2'h2;
  typedef logic [CODE_W-1:0] tws_code_t;
  localparam tws_code_t ST_NONE       = 5'h1F;
  localparam tws_code_t ST_START      = 5'h01;
  localparam tws_code_t ST_RSTART     = 5'h02;
  localparam tws_code_t ST_MADDR_ACK  = 5'h03;
  localparam tws_code_t ST_MADDR_NACK = 5'h04;
  localparam tws_code_t ST_MTXD_ACK   = 5'h05;
  localparam tws_code_t ST_MTXD_NACK  = 5'h06;
  localparam tws_code_t ST_MRXD_ACK   = 5'h07;
  localparam tws_code_t ST_MRXD_NACK  = 5'h08;
  localparam tws_code_t ST_ARB_LOST   = 5'h09;
  localparam tws_code_t ST_SADDR_OWN  = 5'h0A;
  localparam tws_code_t ST_SADDR_GC   = 5'h0B;
  localparam tws_code_t ST_SRXD_ACK   = 5'h0C;
  localparam tws_code_t ST_SRXD_NACK  = 5'h0D;
  localparam tws_code_t ST_STXD_ACK   = 5'h0E;
  localparam tws_code_t ST_STXD_NACK  = 5'h0F;
  localparam tws_code_t ST_SSTOP      = 5'h10;
  localparam tws_code_t ST_BUS_ERR    = 5'h11;
  typedef enum logic [4:0] {
    TS_IDLE  = 5'b00001,
    TS_START = 5'b00010,
    TS_XFER  = 5'b00100,
    TS_HOLD  = 5'b01000,
    TS_STOP  = 5'b10000
  } tws_state_e;
endpackage

/* common/tws_line_if.sv */
// bus line observation and bit rate timing between controller modules
`timescale 1ns/10ps
`default_nettype none
interface tws_line_if;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic run;
  logic scl_held;
  logic half_done;
  modport det (output scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det);
  modport gen (input run, scl_held, scl_s, output half_done);
endinterface
`default_nettype wire

/* src/tws_cond.sv */
// line synchronisers, SCL edge and START/STOP condition detector
`timescale 1ns/10ps
`default_nettype none
module tws_cond (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  tws_line_if.det   l
);
  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic       scl_p;
    logic       sda_p;
    logic       rise;
    logic       fall;
    logic       sta;
    logic       sto;
  } tws_cond_s;

  tws_cond_s q;
  tws_cond_s d;

  always_comb begin
    d        = q;
    d.scl_sy = {q.scl_sy[0], scl_in};
    d.sda_sy = {q.sda_sy[0], sda_in};
    d.scl_p  = q.scl_sy[1];
    d.sda_p  = q.sda_sy[1];
    d.rise   = q.scl_sy[1] & ~q.scl_p;
    d.fall   = ~q.scl_sy[1] & q.scl_p;
    d.sta    = q.scl_sy[1] & q.scl_p & q.sda_p & ~q.sda_sy[1];
    d.sto    = q.scl_sy[1] & q.scl_p & ~q.sda_p & q.sda_sy[1];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{scl_sy: 2'h3, sda_sy: 2'h3, scl_p: 1'b1, sda_p: 1'b1, default: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign l.scl_s     = q.scl_sy[1];
  assign l.sda_s     = q.sda_sy[1];
  assign l.scl_rise  = q.rise;
  assign l.scl_fall  = q.fall;
  assign l.start_det = q.sta;
  assign l.stop_det  = q.sto;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_start_shape: assert property (q.sta |-> q.scl_sy[1] && !q.sto)
    else $error("start detected with SCL low");
endmodule // tws_cond
`default_nettype wire

/* src/tws_bitgen.sv */
// bit rate generator: half period timer for master SCL
`timescale 1ns/10ps
`default_nettype none
module tws_bitgen (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic [tws_pkg::DIV_W-1:0] bit_rate_divider,
  input  wire logic [tws_pkg::PS_W-1:0]  prescaler_sel,
  tws_line_if.gen                        g
);
  import tws_pkg::*;

  typedef struct packed {
    logic [HALF_W-1:0] cnt;
    logic              done;
  } tws_bg_s;

  tws_bg_s           q;
  tws_bg_s           d;
  logic [HALF_W-1:0] half_len;
  logic [2:0]        lsh;

  always_comb begin
    d        = q;
    d.done   = 1'b0;
    lsh      = 3'(PS_SHIFT) * {1'b0, prescaler_sel};
    half_len = HALF_W'(HALF_BASE) + (HALF_W'(bit_rate_divider) << lsh);
    if (!g.run) begin
      d.cnt = '0;
    end else if (g.scl_held || g.scl_s) begin
      if (q.cnt >= half_len - HALF_W'(1)) begin
        d.cnt  = '0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt + HALF_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign g.half_done = q.done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_half_min: assert property (q.done |=> !q.done [*7])
    else $error("half period shorter than base");
  a_stretch_wait: assert property (g.run && !g.scl_held && !g.scl_s |=> !q.done)
    else $error("half period ended while SCL stretched");
endmodule // tws_bitgen
`default_nettype wire

/* src/tws_core.sv */
// control unit, shift register and bus engine of the two-wire serial controller
`timescale 1ns/10ps
`default_nettype none
module tws_core (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       scl_in,
  output logic                            scl_out,
  output logic                            scl_oe,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe,
  input  wire logic                       ctrl_enable,
  input  wire logic                       ctrl_wr,
  input  wire logic                       ctrl_flag_clr,
  input  wire logic                       ctrl_start,
  input  wire logic                       ctrl_stop,
  input  wire logic                       ctrl_ack_en,
  input  wire logic                       event_irq_enable,
  input  wire logic                       global_irq_enable,
  input  wire logic [tws_pkg::DIV_W-1:0]  bit_rate_divider,
  input  wire logic                       prescaler_wr,
  input  wire logic [tws_pkg::PS_W-1:0]   prescaler_in,
  output logic      [tws_pkg::PS_W-1:0]   prescaler_sel,
  input  wire logic [tws_pkg::ADDR_W-1:0] own_address_reg,
  input  wire logic                       general_call_enable,
  input  wire logic                       shift_data_wr,
  input  wire logic [tws_pkg::BYTE_W-1:0] shift_data_in,
  output logic      [tws_pkg::BYTE_W-1:0] shift_data_out,
  input  wire logic                       sleep_mode,
  input  wire logic                       other_wake,
  output logic                            wake_req,
  output logic                            event_flag,
  output logic      [tws_pkg::CODE_W-1:0] status_reg,
  output logic                            irq
);
  import tws_pkg::*;

  typedef struct packed {
    tws_state_e        st;
    logic [1:0]        ph;
    logic [3:0]        cnt;
    logic [BYTE_W-1:0] sh;
    logic              master;
    logic              tx;
    logic              addr_ph;
    logic              addressed;
    logic              lost;
    logic              rep;
    logic              busy;
    logic              start_req;
    logic              stop_req;
    logic              ack_en;
    logic              ack_rx;
    logic              flag;
    logic              ev;
    logic              irq;
    logic              wake;
    logic              lvl;
    logic              scl_oe;
    logic              sda_oe;
    tws_code_t         code;
    tws_code_t         stat;
    logic [PS_W-1:0]   ps;
  } tws_core_s;

  tws_core_s q;
  tws_core_s d;
  logic      match_own;
  logic      match_gc;
  logic      matched;
  logic      ev_set;
  tws_code_t ev_code;

  tws_line_if l ();

  tws_cond u_cond (
    .clk     (clk),
    .reset_n (reset_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .l       (l)
  );

  tws_bitgen u_bitgen (
    .clk              (clk),
    .reset_n          (reset_n),
    .bit_rate_divider (bit_rate_divider),
    .prescaler_sel    (q.ps),
    .g                (l)
  );

  assign l.run      = q.master && (q.st inside {TS_START, TS_STOP, TS_XFER});
  assign l.scl_held = q.scl_oe;

  always_comb begin
    d         = q;
    d.ev      = 1'b0;
    ev_set    = 1'b0;
    ev_code   = ST_NONE;
    match_own = q.sh[BYTE_W-1:1] == own_address_reg;
    match_gc  = general_call_enable && (q.sh[BYTE_W-1:1] == GEN_CALL_ADDR);
    matched   = (match_own || match_gc) && q.ack_en && !q.master;

    if (ctrl_wr) begin
      d.ack_en = ctrl_ack_en;
      if (ctrl_start) begin
        d.start_req = 1'b1;
      end
      if (ctrl_stop) begin
        d.stop_req = 1'b1;
      end
      if (ctrl_flag_clr) begin
        d.flag = 1'b0;
      end
    end
    if (prescaler_wr) begin
      d.ps = prescaler_in;
    end
    if (shift_data_wr) begin
      d.sh = shift_data_in;
    end
    if (l.start_det) begin
      d.busy = 1'b1;
    end
    if (l.stop_det) begin
      d.busy = 1'b0;
    end

    case (q.st)
      TS_IDLE: begin
        d.scl_oe    = 1'b0;
        d.sda_oe    = 1'b0;
        d.master    = 1'b0;
        d.addressed = 1'b0;
        if (q.start_req && !q.busy && !q.flag) begin
          d.st        = TS_START;
          d.ph        = PH_FIRST;
          d.master    = 1'b1;
          d.rep       = 1'b0;
          d.start_req = 1'b0;
        end else if (l.start_det) begin
          d.st      = TS_XFER;
          d.cnt     = CNT_ZERO;
          d.addr_ph = 1'b1;
          d.tx      = 1'b0;
        end
      end
      TS_START, TS_STOP: begin
        if (l.half_done) begin
          if (q.ph == PH_FIRST) begin
            d.scl_oe = 1'b0;
            d.ph     = PH_MID;
          end else if (q.ph == PH_MID) begin
            d.sda_oe = q.st == TS_START;
            d.ph     = PH_LAST;
          end else if (q.st == TS_START) begin
            d.cnt     = CNT_ZERO;
            d.addr_ph = 1'b1;
            d.tx      = 1'b1;
            d.lost    = 1'b0;
            ev_set    = 1'b1;
            ev_code   = q.rep ? ST_RSTART : ST_START;
          end else begin
            d.st     = TS_IDLE;
            d.master = 1'b0;
          end
        end
      end
      TS_XFER: begin
        if (q.master && l.half_done) begin
          d.scl_oe = !q.scl_oe;
        end
        if (l.scl_rise) begin
          if (q.cnt < BITS_DATA) begin
            d.sh = {q.sh[BYTE_W-2:0], l.sda_s};
            if (q.master && q.tx && !q.sda_oe && !l.sda_s) begin
              d.lost   = 1'b1;
              d.master = 1'b0;
              d.tx     = 1'b0;
              d.scl_oe = 1'b0;
              d.sda_oe = 1'b0;
            end
          end else begin
            d.ack_rx = l.sda_s;
          end
          d.cnt = q.cnt + 4'h1;
        end
        if (l.scl_fall) begin
          if (q.cnt == BITS_PKT) begin
            d.addr_ph = 1'b0;
            if (q.master) begin
              ev_set = 1'b1;
              if (q.addr_ph) begin
                d.tx    = !q.sh[0];
                ev_code = q.ack_rx ? ST_MADDR_NACK : ST_MADDR_ACK;
              end else if (q.tx) begin
                ev_code = q.ack_rx ? ST_MTXD_NACK : ST_MTXD_ACK;
              end else begin
                ev_code = q.ack_rx ? ST_MRXD_NACK : ST_MRXD_ACK;
              end
            end else if (q.addr_ph && matched) begin
              d.addressed = 1'b1;
              d.tx        = q.sh[0];
              ev_set      = 1'b1;
              ev_code     = match_own ? ST_SADDR_OWN : ST_SADDR_GC;
              if (sleep_mode) begin
                d.wake = 1'b1;
              end
            end else if (q.lost) begin
              ev_set  = 1'b1;
              ev_code = ST_ARB_LOST;
            end else if (q.addressed) begin
              ev_set = 1'b1;
              if (q.tx) begin
                ev_code = q.ack_rx ? ST_STXD_NACK : ST_STXD_ACK;
              end else begin
                ev_code = q.ack_rx ? ST_SRXD_NACK : ST_SRXD_ACK;
              end
            end else begin
              d.st     = TS_IDLE;
              d.sda_oe = 1'b0;
            end
          end else if (q.cnt == BITS_DATA) begin
            d.sda_oe = !q.tx && (q.addr_ph ? matched : q.ack_en);
          end else begin
            d.sda_oe = q.tx && !q.sh[BYTE_W-1];
          end
        end
        if (l.start_det || l.stop_det) begin
          d.cnt       = CNT_ZERO;
          d.sda_oe    = 1'b0;
          d.tx        = 1'b0;
          d.addr_ph   = l.start_det;
          d.addressed = 1'b0;
          d.lost      = 1'b0;
          ev_set      = 1'b0;
          if (q.addressed && q.cnt <= BIT_FIRST) begin
            ev_set  = 1'b1;
            ev_code = ST_SSTOP;
          end else if (q.master || q.addressed) begin
            d.master = 1'b0;
            d.scl_oe = 1'b0;
            ev_set   = 1'b1;
            ev_code  = ST_BUS_ERR;
          end else if (l.stop_det) begin
            d.st = TS_IDLE;
          end
        end
        if (sleep_mode && other_wake && q.addr_ph && !q.master && !ev_set) begin
          d.st     = TS_IDLE;
          d.sda_oe = 1'b0;
        end
      end
      TS_HOLD: begin
        d.scl_oe = 1'b1;
        if (!q.flag) begin
          d.lost = 1'b0;
          d.cnt  = CNT_ZERO;
          if (!q.master) begin
            d.stop_req = 1'b0;
          end
          if (q.master && q.start_req) begin
            d.st        = TS_START;
            d.ph        = PH_FIRST;
            d.rep       = 1'b1;
            d.start_req = 1'b0;
            d.sda_oe    = 1'b0;
          end else if (q.master && q.stop_req) begin
            d.st       = TS_STOP;
            d.ph       = PH_FIRST;
            d.stop_req = 1'b0;
            d.sda_oe   = 1'b1;
          end else if (q.master || q.addressed || q.addr_ph) begin
            d.st     = TS_XFER;
            d.scl_oe = q.master;
            d.sda_oe = q.tx && !q.sh[BYTE_W-1];
          end else begin
            d.st     = TS_IDLE;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
          end
        end
      end
      default: begin
        d.st = TS_IDLE;
      end
    endcase

    if (ev_set) begin
      d.flag   = 1'b1;
      d.ev     = 1'b1;
      d.code   = ev_code;
      d.st     = TS_HOLD;
      d.scl_oe = 1'b1;
    end
    if (!ctrl_enable) begin
      d.st        = TS_IDLE;
      d.flag      = 1'b0;
      d.ev        = 1'b0;
      d.master    = 1'b0;
      d.addressed = 1'b0;
      d.addr_ph   = 1'b0;
      d.scl_oe    = 1'b0;
      d.sda_oe    = 1'b0;
    end
    if (q.ev) begin
      d.stat = q.code;
    end else if (!d.flag) begin
      d.stat = ST_NONE;
    end
    d.irq = q.flag && event_irq_enable && global_irq_enable;
    if (!sleep_mode) begin
      d.wake = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{st: TS_IDLE, code: ST_NONE, stat: ST_NONE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign scl_out        = q.lvl;
  assign scl_oe         = q.scl_oe;
  assign sda_out        = q.lvl;
  assign sda_oe         = q.sda_oe;
  assign prescaler_sel  = q.ps;
  assign shift_data_out = q.sh;
  assign wake_req       = q.wake;
  assign event_flag     = q.flag;
  assign status_reg     = q.stat;
  assign irq            = q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_resume;
    q.st == TS_HOLD && !q.flag && ctrl_enable;
  endsequence

  sequence s_stop_end;
    q.st == TS_STOP && q.ph == PH_LAST && l.half_done && ctrl_enable;
  endsequence

  a_status_load: assert property (q.ev |=> q.stat == $past(q.code))
    else $error("status code not loaded after flag");
  a_status_none: assert property (!q.flag && !$past(q.ev) |-> q.stat == ST_NONE)
    else $error("status code valid without flag");
  a_flag_holds_scl: assert property (q.flag |-> q.scl_oe && q.st == TS_HOLD)
    else $error("SCL not held while flag set");
  a_irq_gate: assert property (q.irq |-> $past(q.flag) && $past(event_irq_enable)
    && $past(global_irq_enable))
    else $error("interrupt without all enables");
  a_flag_clear: assert property (q.flag && ctrl_wr && ctrl_flag_clr |=> !q.flag)
    else $error("flag survived clear write");
  a_resume_start: assert property (s_resume ##0 q.master && q.start_req
    |=> q.st == TS_START && q.ph == PH_FIRST)
    else $error("requested start not begun after clear");
  a_stop_quiet: assert property (s_stop_end |=> q.st == TS_IDLE && !q.flag [*2])
    else $error("flag raised after stop");
  a_arb_release: assert property ($rose(q.lost) |-> !q.sda_oe && !q.master)
    else $error("SDA driven after arbitration loss");
endmodule // tws_core
`default_nettype wire

/* test/tws_slave_model.sv */
// open-drain slave on the two-wire bus, acks its address and bytes
`timescale 1ns/10ps
`default_nettype none
module tws_slave_model #(
  parameter logic [6:0] ADDR = 7'h3A
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       stretch,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh;
  logic       sel;
  logic       first;
  int         n;
  initial begin
    {scl_oe, sda_oe, sel, first, sh, rx_byte} = '0;
    n = 0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    n = 0;
    first = 1'b1;
    sel = 1'b0;
  end
  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    n++;
  end
  always @(negedge scl) begin
    if (n == 8) begin
      if (first) sel = (sh[7:1] == ADDR);
      else rx_byte = sh;
      sda_oe = sel;
    end else if (n == 9) begin
      sda_oe = 1'b0;
      n = 0;
      first = 1'b0;
    end
    if (stretch) begin
      scl_oe = 1'b1;
      #200;
      scl_oe = 1'b0;
    end
  end
endmodule // tws_slave_model
`default_nettype wire

/* test/tws_core_tb.sv */
// self-checking bench: master transfers against a slave model
`timescale 1ns/10ps
`default_nettype none
module tws_core_tb;
  import tws_pkg::*;
  localparam logic [6:0] SLV = 7'h3A;
  localparam int DIV = 2;
  localparam int PER = 16 + 2 * DIV;
  logic clk = 0, reset_n = 0, stretch = 0;
  logic ctrl_wr = 0, ctrl_flag_clr = 0, ctrl_start = 0, ctrl_stop = 0;
  logic global_irq_enable = 1, prescaler_wr = 0, shift_data_wr = 0;
  logic ctrl_enable = 1, ctrl_ack_en = 1, event_irq_enable = 1;
  logic [1:0] prescaler_in = 0;
  logic [7:0] shift_data_in = 0;
  logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, event_flag, irq;
  logic [1:0] prescaler_sel;
  logic [4:0] status_reg;
  logic [7:0] rx_byte;
  wire logic scl = ~(scl_oe | m_scl_oe);
  wire logic sda = ~(sda_oe | m_sda_oe);
  int fails = 0, checked = 0;
  always #5 clk = ~clk;
  tws_core u_tws_core (.clk(clk), .reset_n(reset_n), .scl_in(scl), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .ctrl_enable(ctrl_enable),
    .ctrl_wr(ctrl_wr), .ctrl_flag_clr(ctrl_flag_clr), .ctrl_start(ctrl_start),
    .ctrl_stop(ctrl_stop), .ctrl_ack_en(ctrl_ack_en), .event_irq_enable(event_irq_enable),
    .global_irq_enable(global_irq_enable), .bit_rate_divider(8'(DIV)),
    .prescaler_wr(prescaler_wr), .prescaler_in(prescaler_in),
    .prescaler_sel(prescaler_sel), .own_address_reg(7'h15), .general_call_enable(1'b0),
    .shift_data_wr(shift_data_wr), .shift_data_in(shift_data_in), .shift_data_out(),
    .sleep_mode(1'b0), .other_wake(1'b0), .wake_req(), .event_flag(event_flag),
    .status_reg(status_reg), .irq(irq));
  tws_slave_model #(.ADDR(SLV)) u_tws_slave_model (.scl(scl), .sda(sda),
    .stretch(stretch), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .rx_byte(rx_byte));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic ctl(input logic c, input logic s, input logic p);
    @(negedge clk);
    {ctrl_wr, ctrl_flag_clr, ctrl_start, ctrl_stop} = {1'b1, c, s, p};
    @(negedge clk);
    ctrl_wr = 0;
    chk("flag_clr", 0, event_flag);
    chk("idle_code", ST_NONE, status_reg);
  endtask
  task automatic load(input logic [7:0] b);
    @(negedge clk);
    {shift_data_wr, shift_data_in} = {1'b1, b};
    @(negedge clk);
    shift_data_wr = 0;
  endtask
  task automatic wflag(input logic [7:0] code);
    int k;
    k = 0;
    while (event_flag !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    chk("flag", 1, event_flag);
    chk("code_before", ST_NONE, status_reg);
    @(negedge clk);
    chk("status", code, status_reg);
  endtask
  task automatic period;
    int k;
    k = 0;
    @(negedge scl);
    while (scl !== 1'b1 && k < 500) begin
      @(negedge clk);
      k++;
    end
    while (scl !== 1'b0 && k < 500) begin
      @(negedge clk);
      k++;
    end
    checked++;
    if (k < PER || k > PER + 6) begin
      $display("mismatch scl_period expected %0d seen %0d", PER, k);
      fails++;
    end
  endtask
  task automatic t_reset;
    chk("rst_status", ST_NONE, status_reg);
    chk("rst_lines", 0, {event_flag, scl_oe, sda_oe, irq, prescaler_sel});
    $display("test reset done");
  endtask
  task automatic t_write;
    ctl(1, 1, 0);
    wflag(ST_START);
    repeat (40) @(negedge clk);
    chk("scl_held", 2'b10, {scl_oe, scl});
    chk("irq_on", 1, irq);
    global_irq_enable = 0;
    repeat (2) @(negedge clk);
    chk("irq_off", 0, irq);
    global_irq_enable = 1;
    event_irq_enable = 0;
    repeat (2) @(negedge clk);
    chk("irq_local_off", 0, irq);
    event_irq_enable = 1;
    {prescaler_wr, prescaler_in} = 3'b101;
    @(negedge clk);
    prescaler_wr = 0;
    @(negedge clk);
    chk("ps", 1, prescaler_sel);
    chk("ps_status", ST_START, status_reg);
    {prescaler_wr, prescaler_in} = 3'b100;
    load({SLV, 1'b0});
    ctl(1, 0, 0);
    wflag(ST_MADDR_ACK);
    load(8'hA5);
    ctl(1, 0, 0);
    period();
    wflag(ST_MTXD_ACK);
    chk("slave_rx", 8'hA5, rx_byte);
    ctl(1, 0, 1);
    repeat (300) @(negedge clk);
    chk("stop", 0, {event_flag, scl_oe, sda_oe});
    $display("test write done");
  endtask
  task automatic t_addr(input logic [6:0] a, input logic s, input logic [7:0] code);
    stretch = s;
    ctl(1, 1, 0);
    wflag(ST_START);
    load({a, 1'b0});
    ctl(1, 0, 0);
    wflag(code);
    stretch = 0;
    ctl(1, 0, 1);
    repeat (300) @(negedge clk);
    chk("stop_flag", 0, event_flag);
    $display("test address %h done", a);
  endtask
  task automatic stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #900us;
    fails++;
    stop_test();
  end
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1;
    repeat (5) @(negedge clk);
    t_reset();
    t_write();
    t_addr(7'h11, 0, ST_MADDR_NACK);
    t_addr(SLV, 1, ST_MADDR_ACK);
    stop_test();
  end
endmodule // tws_core_tb
`default_nettype wire
